// [pkg/relay_ie_pkg.sv]
package relay_ie_pkg;

  // ************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ************************************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_CSF       = 8'h04;
  localparam logic [7:0] REG_SSF       = 8'h08;
  localparam logic [7:0] REG_BMAP_ADDR = 8'h0c;
  localparam logic [7:0] REG_BMAP_DATA = 8'h10;
  localparam logic [7:0] REG_PEND_CLR  = 8'h14;
  localparam logic [7:0] REG_PEND_DATA = 8'h18;
  localparam logic [7:0] REG_ACK_CTRL  = 8'h1c;
  localparam logic [7:0] REG_ACK_DATA  = 8'h20;
  localparam logic [7:0] REG_STATUS    = 8'h24;
  localparam logic [7:0] REG_RX        = 8'h28;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_REPEATER = 1;
  localparam int CTRL_COORD    = 2;
  localparam int CTRL_TIER_LSB = 4;
  localparam int SSF_GLA_LSB   = 9;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_ORD_ERR  = 1;
  localparam int STAT_TYPE_ERR = 2;
  localparam int STAT_CNT_LSB  = 8;

  // ************************************************************
  // encodings and limits
  // ************************************************************
  localparam logic [1:0] ACK_END_TO_END = 2'b00;
  localparam logic [1:0] ACK_SLOT_LINK  = 2'b01;
  localparam logic [1:0] ACK_GROUP      = 2'b10;
  localparam logic [1:0] ACK_RESERVED   = 2'b11;
  localparam logic [4:0] BMAP_ORD_BIAS  = 5'd3;
  localparam logic [4:0] BMAP_ORD_MAX   = 5'd9;
  localparam logic [7:0] BMAP_MAX_OCT   = 8'd64;
  localparam int         PEND_DEPTH     = 16;
  localparam int         ACK_DEPTH      = 15;
  localparam logic [7:0] TIME_OCTETS    = 8'd6;
  localparam logic [7:0] CSF_OCTETS     = 8'd2;
  localparam logic [7:0] RELAY_OCTETS   = 8'd2;
  localparam logic [15:0] CSF_RESET     = 16'h0000;

  typedef enum logic [2:0] {KIND_BEACON, KIND_DATA, KIND_ACK, KIND_CMD, KIND_FRAG} frame_kind_t;
  typedef enum logic [1:0] {IE_FRAG, IE_PAN, IE_RELAY, IE_ACKD} ie_sel_t;
  typedef enum logic {ST_IDLE, ST_EMIT} emit_state_t;

  typedef struct packed {
    logic        src_pan_present;
    logic        dst_pan_present;
    logic [1:0]  src_mode;
    logic [1:0]  dst_mode;
    logic [15:0] src_pan;
    logic [15:0] dst_pan;
    logic [63:0] src_addr;
    logic [63:0] dst_addr;
  } hdr_t;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
  } tx_byte_t;

  typedef struct packed {
    logic        valid;
    logic        is_ack_ctrl;
    logic [15:0] word;
  } rx_ie_t;

endpackage

// [design/relay_net_ie_formatter.sv]
// Operation
// - addressing field: src/dst pan, src/dst address
// - addressing values copied from fragmented frame header
// - presence bits and mode fields reflect included subfields
// - enhanced beacons carry the pan descriptor
// - descriptor: superframe spec, time, relaying, pending
// - superframe spec orders and slot counts layout
// - slot counts: prioritized device, coordinator outward
// - timestamp is start of transmit slot
// - relaying spec then beacon bitmap of 1..64 octets
// - bitmap bit one when neighbour beacon occupies slot
// - bitmap length from order difference, capped 64
// - pending count octet then pending identifiers
// - pending identifier tier, slot, superframe index layout
// - tier of generating node, coordinator is zero
// - data, ack, command frames carry relaying spec
// - relaying spec tier, repeater, grade, sync, index
// - repeater flag one only for repeater
// - sync flag one at first slotted-superframe
// - index counts from coordinator cycle start
// - ack descriptor: control, time, sequence list
// - ack control type, group count, reserved layout
// - ack type encodings; reserved value never sent
// - group mode lists sequence numbers, count matches
module relay_net_ie_formatter
  import relay_ie_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  input  wire frame_kind_t req_kind,
  input  wire hdr_t        req_hdr,
  input  wire logic [47:0] slot_start_us,
  output logic             req_ready,
  output tx_byte_t         tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire rx_ie_t      rx_ie
);

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  ctrl_ff;
  logic [15:0] csf_ff;
  logic [10:0] ssf_ff;
  logic [3:0]  bmap_addr_ff;
  logic [7:0]  bmap_mem [64];
  logic [15:0] pend_mem [PEND_DEPTH];
  logic [4:0]  pend_cnt_ff;
  logic [1:0]  ack_type_ff;
  logic [7:0]  ack_mem [ACK_DEPTH];
  logic [3:0]  ack_cnt_ff;
  logic        ord_err_ff;
  logic        type_err_ff;
  logic [15:0] rx_relay_ff;
  logic [5:0]  rx_ack_ff;
  logic [15:0] byte_cnt_ff;
  emit_state_t state_ff;
  ie_sel_t     ie_ff;
  logic        ack_follow_ff;
  logic [7:0]  idx_ff;
  hdr_t        hdr_ff;
  logic [47:0] time_ff;
  logic        req_ready_ff;
  tx_byte_t    tx_ff;
  logic        tx_valid_ff;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_c;
  logic [15:0] relay_word;
  logic [7:0]  bmap_len;
  logic        ord_bad;
  logic [7:0]  byte_c;
  logic [7:0]  len_c;
  logic        load;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign req_ready = req_ready_ff;
  assign tx_byte   = tx_ff;
  assign tx_valid  = tx_valid_ff;

  // ************************************************************
  // apb slave: one wait state, answer in second access cycle
  // ************************************************************
  assign wr_en = psel && penable && pready_ff && pwrite;
  assign rd_en = psel && penable && !pready_ff && !pwrite;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_c    = 32'h0000_0000;
    unique case (paddr)
      REG_CTRL:      rd_c = {24'h00_0000, ctrl_ff};
      REG_CSF:       rd_c = {16'h0000, csf_ff};
      REG_SSF:       rd_c = {21'h00_0000, ssf_ff};
      REG_BMAP_ADDR: rd_c = {28'h000_0000, bmap_addr_ff};
      REG_BMAP_DATA: rd_c = 32'h0000_0000;
      REG_PEND_CLR:  rd_c = {27'h000_0000, pend_cnt_ff};
      REG_PEND_DATA: rd_c = 32'h0000_0000;
      REG_ACK_CTRL:  rd_c = {26'h000_0000, ack_cnt_ff, ack_type_ff};
      REG_ACK_DATA:  rd_c = 32'h0000_0000;
      REG_STATUS:    rd_c = {8'h00, byte_cnt_ff, 5'h00, type_err_ff, ord_err_ff, state_ff == ST_EMIT};
      REG_RX:        rd_c = {10'h000, rx_ack_ff, rx_relay_ff};
      default:       addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
      // an unmapped access of either direction answers zero data
      if (rd_en || (psel && penable && !pready_ff && !addr_ok))
        prdata_ff <= rd_c;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_ff      <= 8'h00;
      csf_ff       <= CSF_RESET;
      ssf_ff       <= 11'h000;
      bmap_addr_ff <= 4'h0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        REG_CTRL:      ctrl_ff <= pwdata[7:0];
        REG_CSF:       csf_ff <= pwdata[15:0];
        REG_SSF:       ssf_ff <= pwdata[10:0];
        REG_BMAP_ADDR: bmap_addr_ff <= pwdata[3:0];
        REG_BMAP_DATA: bmap_addr_ff <= bmap_addr_ff + 4'h1;
        default:       ;
      endcase
    end
  end

  // a bitmap word covers four slot octets, lowest octet first
  always_ff @(posedge ref_clk)
  begin
    if (wr_en && paddr == REG_BMAP_DATA)
      for (int k = 0; k < 4; k++)
        bmap_mem[{bmap_addr_ff, 2'(k)}] <= pwdata[8*k +: 8];
  end

  // ************************************************************
  // pending slot list and acknowledged sequence list
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pend_cnt_ff <= 5'd0;
    else if (wr_en && paddr == REG_PEND_CLR)
      pend_cnt_ff <= 5'd0;
    else if (wr_en && paddr == REG_PEND_DATA && pend_cnt_ff != 5'(PEND_DEPTH))
      pend_cnt_ff <= pend_cnt_ff + 5'd1;
  end

  // entries past the depth are dropped rather than wrapping over earlier ones
  always_ff @(posedge ref_clk)
  begin
    if (wr_en && paddr == REG_PEND_DATA && pend_cnt_ff != 5'(PEND_DEPTH))
      pend_mem[pend_cnt_ff[3:0]] <= pwdata[15:0];
    if (wr_en && paddr == REG_ACK_DATA && ack_cnt_ff != 4'(ACK_DEPTH))
      ack_mem[ack_cnt_ff] <= pwdata[7:0];
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_type_ff <= ACK_END_TO_END;
      ack_cnt_ff  <= 4'd0;
      type_err_ff <= 1'b0;
    end
    else if (wr_en && paddr == REG_ACK_CTRL)
    begin
      // the reserved type is refused so it can never reach the air
      if (pwdata[1:0] == ACK_RESERVED)
        type_err_ff <= 1'b1;
      else
      begin
        ack_type_ff <= pwdata[1:0];
        type_err_ff <= 1'b0;
      end
      if (pwdata[2])
        ack_cnt_ff <= 4'd0;
    end
    else if (wr_en && paddr == REG_ACK_DATA && ack_cnt_ff != 4'(ACK_DEPTH))
      ack_cnt_ff <= ack_cnt_ff + 4'd1;
  end

  // ************************************************************
  // reception: reserved bits dropped
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_relay_ff <= 16'h0000;
      rx_ack_ff   <= 6'h00;
    end
    else if (rx_ie.valid)
    begin
      if (rx_ie.is_ack_ctrl)
        rx_ack_ff <= rx_ie.word[5:0];
      else
        rx_relay_ff <= rx_ie.word;
    end
  end

  // ************************************************************
  // derived fields
  // ************************************************************
  always_comb
  begin
    logic [4:0] diff;
    diff = 5'(csf_ff[3:0]) - 5'(csf_ff[7:4]);
    ord_bad  = 1'b0;
    bmap_len = 8'd1;
    if (csf_ff[3:0] < csf_ff[7:4] || diff < BMAP_ORD_BIAS)
      bmap_len = 8'd1;
    else if (diff > BMAP_ORD_MAX)
    begin
      ord_bad  = 1'b1;
      bmap_len = BMAP_MAX_OCT;
    end
    else
      bmap_len = 8'd1 << (diff - BMAP_ORD_BIAS);
  end

  // coordinator tier forced to zero; sync flag marks index zero
  assign relay_word = {ssf_ff[8:0],
                       ssf_ff[8:0] == 9'd0,
                       ssf_ff[SSF_GLA_LSB +: 2],
                       ctrl_ff[CTRL_REPEATER],
                       ctrl_ff[CTRL_COORD] ? 3'd0 : ctrl_ff[CTRL_TIER_LSB +: 3]};

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ord_err_ff <= 1'b0;
    else
      ord_err_ff <= ord_bad;
  end

  function automatic logic [7:0] addr_octets(input logic [1:0] mode);
    unique case (mode)
      2'b00: addr_octets = 8'd0;
      2'b01: addr_octets = 8'd1;
      2'b10: addr_octets = 8'd2;
      2'b11: addr_octets = 8'd8;
    endcase
  endfunction

  // ************************************************************
  // byte selection for the element being emitted
  // ************************************************************
  always_comb
  begin
    logic [7:0] o_dp;
    logic [7:0] o_sa;
    logic [7:0] o_da;
    logic [7:0] o_bm;
    logic [7:0] o_pc;
    logic [7:0] k;
    logic [3:0] grp;
    o_dp   = 8'd1 + (hdr_ff.src_pan_present ? 8'd2 : 8'd0);
    o_sa   = o_dp + (hdr_ff.dst_pan_present ? 8'd2 : 8'd0);
    o_da   = o_sa + addr_octets(hdr_ff.src_mode);
    o_bm   = CSF_OCTETS + TIME_OCTETS + RELAY_OCTETS;
    o_pc   = o_bm + bmap_len;
    grp    = (ack_type_ff == ACK_GROUP) ? ack_cnt_ff : 4'd0;
    k      = 8'd0;
    byte_c = 8'h00;
    len_c  = 8'd1;
    unique case (ie_ff)
      IE_FRAG:
      begin
        len_c = o_da + addr_octets(hdr_ff.dst_mode);
        if (idx_ff == 8'd0)
          byte_c = {2'b00, hdr_ff.dst_mode, hdr_ff.src_mode,
                    hdr_ff.dst_pan_present, hdr_ff.src_pan_present};
        else if (idx_ff < o_dp)
        begin
          k = idx_ff - 8'd1;
          byte_c = hdr_ff.src_pan[{k[0], 3'b000} +: 8];
        end
        else if (idx_ff < o_sa)
        begin
          k = idx_ff - o_dp;
          byte_c = hdr_ff.dst_pan[{k[0], 3'b000} +: 8];
        end
        else if (idx_ff < o_da)
        begin
          k = idx_ff - o_sa;
          byte_c = hdr_ff.src_addr[{k[2:0], 3'b000} +: 8];
        end
        else
        begin
          k = idx_ff - o_da;
          byte_c = hdr_ff.dst_addr[{k[2:0], 3'b000} +: 8];
        end
      end
      IE_PAN:
      begin
        len_c = o_pc + 8'd1 + {2'b00, pend_cnt_ff, 1'b0};
        if (idx_ff < CSF_OCTETS)
          byte_c = csf_ff[{idx_ff[0], 3'b000} +: 8];
        else if (idx_ff < CSF_OCTETS + TIME_OCTETS)
        begin
          k = idx_ff - CSF_OCTETS;
          byte_c = time_ff[{k[2:0], 3'b000} +: 8];
        end
        else if (idx_ff < o_bm)
          byte_c = relay_word[{idx_ff[0], 3'b000} +: 8];
        else if (idx_ff < o_pc)
        begin
          k = idx_ff - o_bm;
          byte_c = bmap_mem[k[5:0]];
        end
        else if (idx_ff == o_pc)
          byte_c = {3'b000, pend_cnt_ff};
        else
        begin
          k = idx_ff - o_pc - 8'd1;
          byte_c = pend_mem[k[4:1]][{k[0], 3'b000} +: 8];
        end
      end
      IE_RELAY:
      begin
        len_c  = RELAY_OCTETS;
        byte_c = relay_word[{idx_ff[0], 3'b000} +: 8];
      end
      IE_ACKD:
      begin
        len_c = 8'd1 + TIME_OCTETS + {4'h0, grp};
        if (idx_ff == 8'd0)
          byte_c = {2'b00, grp, ack_type_ff};
        else if (idx_ff <= TIME_OCTETS)
        begin
          k = idx_ff - 8'd1;
          byte_c = time_ff[{k[2:0], 3'b000} +: 8];
        end
        else
        begin
          k = idx_ff - 8'd1 - TIME_OCTETS;
          byte_c = ack_mem[k[3:0]];
        end
      end
    endcase
  end

  // ************************************************************
  // request acceptance and byte sequencing
  // ************************************************************
  assign load = state_ff == ST_EMIT && (!tx_valid_ff || tx_ready);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff      <= ST_IDLE;
      ie_ff         <= IE_RELAY;
      ack_follow_ff <= 1'b0;
      idx_ff        <= 8'd0;
      req_ready_ff  <= 1'b1;
    end
    else if (state_ff == ST_IDLE)
    begin
      if (req_valid && req_ready_ff)
      begin
        idx_ff        <= 8'd0;
        ack_follow_ff <= req_kind == KIND_ACK;
        unique case (req_kind)
          KIND_BEACON: ie_ff <= IE_PAN;
          KIND_FRAG:   ie_ff <= IE_FRAG;
          default:     ie_ff <= IE_RELAY;
        endcase
        // outside a relaying network only the fragment element is built
        if (ctrl_ff[CTRL_ENABLE] || req_kind == KIND_FRAG)
        begin
          state_ff     <= ST_EMIT;
          req_ready_ff <= 1'b0;
        end
      end
    end
    else if (load)
    begin
      if (idx_ff == len_c - 8'd1)
      begin
        idx_ff <= 8'd0;
        if (ie_ff == IE_RELAY && ack_follow_ff)
        begin
          ie_ff         <= IE_ACKD;
          ack_follow_ff <= 1'b0;
        end
        else
        begin
          state_ff     <= ST_IDLE;
          req_ready_ff <= 1'b1;
        end
      end
      else
        idx_ff <= idx_ff + 8'd1;
    end
  end

  // header and slot time are frozen for the whole frame
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hdr_ff  <= '0;
      time_ff <= 48'h0000_0000_0000;
    end
    else if (state_ff == ST_IDLE && req_valid && req_ready_ff)
    begin
      hdr_ff  <= req_hdr;
      time_ff <= slot_start_us;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_ff       <= '0;
      tx_valid_ff <= 1'b0;
      byte_cnt_ff <= 16'h0000;
    end
    else if (load)
    begin
      tx_ff.data  <= byte_c;
      tx_ff.first <= idx_ff == 8'd0;
      tx_ff.last  <= idx_ff == len_c - 8'd1;
      tx_valid_ff <= 1'b1;
      byte_cnt_ff <= byte_cnt_ff + 16'h0001;
    end
    else if (tx_ready)
      tx_valid_ff <= 1'b0;
  end

endmodule

// [test/relay_ie_checker.sv]
module relay_ie_checker
  import relay_ie_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        req_valid,
  input wire frame_kind_t req_kind,
  input wire logic        req_ready,
  input wire tx_byte_t    tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ****************
  // bus and stream
  // ****************
  AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready not in second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED_ERR: assert property (pready && paddr > REG_RX |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (pready && paddr <= REG_RX && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte changed while stalled");
  AST_TX_START: assert property ($fell(req_ready) |=> tx_valid && tx_byte.first)
    else $error("element did not start on time");
  AST_FRAG_TAKEN: assert property (req_valid && req_ready && req_kind == KIND_FRAG |=> !req_ready)
    else $error("fragment request not taken");
endmodule

bind relay_net_ie_formatter relay_ie_checker u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
  .req_kind(req_kind), .req_ready(req_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
  .tx_ready(tx_ready));

// [test/peer_mac.sv]
module peer_mac
  import relay_ie_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     resetn,
  input  wire logic     slow,
  input  wire tx_byte_t tx_byte,
  input  wire logic     tx_valid,
  output logic          tx_ready,
  output rx_ie_t        rx_ie
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int         n_last;
  logic [1:0] stall_ff;

  // stalls three cycles in four when slow, so held bytes are seen
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      stall_ff <= 2'b00;
    else
      stall_ff <= stall_ff + 2'b01;

  assign tx_ready = !slow || (stall_ff == 2'b11);

  // only data and last flags are kept; the first flag plays no part
  always @(posedge ref_clk)
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_byte.data);
      if (tx_byte.last)
        n_last++;
    end

  initial
    rx_ie = '0;

  // idle word is inverted so a stale value is never mistaken for data
  task automatic send(input logic ack, input logic [15:0] w);
    @(posedge ref_clk);
    rx_ie <= '{1'b1, ack, w};
    @(posedge ref_clk);
    rx_ie <= '{1'b0, 1'b0, ~w};
  endtask
endmodule

// [test/tb.sv]
module tb
  import relay_ie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        req_valid;
  frame_kind_t req_kind;
  hdr_t        req_hdr;
  logic [47:0] slot_start_us;
  logic        req_ready;
  tx_byte_t    tx_byte;
  logic        tx_valid;
  logic        tx_ready;
  rx_ie_t      rx_ie;
  logic        slow;
  logic [7:0]  exp[$];
  int          n_mismatch;
  int          tests_run;

  relay_net_ie_formatter dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_kind(req_kind), .req_hdr(req_hdr),
    .slot_start_us(slot_start_us), .req_ready(req_ready), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_ie(rx_ie));
  peer_mac peer (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_ie(rx_ie));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test;
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait limit here: a slave that never answers is caught by the watchdog
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic push16(input logic [15:0] v);
    exp.push_back(v[7:0]);
    exp.push_back(v[15:8]);
  endtask

  task automatic push_t;
    for (int i = 0; i < 6; i++)
      exp.push_back(slot_start_us[8*i +: 8]);
  endtask

  function automatic logic [15:0] relay(input logic [8:0] s, input logic [1:0] g,
                                        input logic r, input logic [2:0] t);
    return {s, s == 9'd0, g, r, t};
  endfunction

  // first byte can appear no sooner than one edge after the accept edge
  task automatic req(input frame_kind_t k, input int n, input int n_el);
    int w;
    peer.got.delete();
    peer.n_last = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_kind  <= k;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    w = 0;
    while ((req_ready !== 1'b1 || tx_valid !== 1'b0) && w < 3000)
    begin
      @(posedge ref_clk);
      w++;
    end
    check(peer.got.size(), n);
    check(peer.n_last, n_el);
    foreach (exp[i])
      check({24'h0, peer.got[i]}, {24'h0, exp[i]});
    exp.delete();
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(REG_CTRL, q);
    check(q, 32'h0);
    wr(REG_CTRL, 32'h57);
    rd(REG_CTRL, q);
    check(q, 32'h57);
    apb(1'b1, 8'h40, 32'hffff_ffff, q, e);
    check(32'(e), 32'h1);
    check(q, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_relay;
    logic [7:0]  c[3] = '{8'h53, 8'h57, 8'h31};
    logic [10:0] s[3] = '{11'h400, 11'h203, 11'h7ff};
    for (int i = 0; i < 3; i++)
    begin
      wr(REG_CTRL, {24'h0, c[i]});
      wr(REG_SSF, {21'h0, s[i]});
      push16(relay(s[i][8:0], s[i][10:9], c[i][1], c[i][2] ? 3'd0 : c[i][6:4]));
      slow <= (i == 1);
      req(i == 0 ? KIND_DATA : KIND_CMD, 2, 1);
    end
    $display("t_relay done");
  endtask

  task automatic t_pan;
    logic [31:0] q;
    logic [15:0] f[4] = '{16'h5326, 16'h0012, 16'h0009, 16'h000f};
    int          n[4] = '{15, 14, 77, 77};
    wr(REG_CTRL, 32'h1);
    wr(REG_SSF, 32'h0);
    wr(REG_BMAP_ADDR, 32'h0);
    for (int j = 0; j < 16; j++)
      wr(REG_BMAP_DATA, 32'h0000a55a);
    wr(REG_PEND_CLR, 32'h0);
    wr(REG_PEND_DATA, 32'h1234);
    rd(REG_PEND_CLR, q);
    check(q, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_CSF, {16'h0, f[i]});
      slow <= i[0];
      if (!i[0])
      begin
        push16(f[i]);
        push_t();
        push16(16'h0040);
        for (int j = 0; j < (i == 0 ? 1 : 16); j++)
        begin
          push16(16'ha55a);
          if (i == 2)
            push16(16'h0000);
        end
        exp.push_back(8'h01);
        push16(16'h1234);
      end
      req(KIND_BEACON, n[i], 1);
    end
    rd(REG_STATUS, q);
    check(32'(q[1]), 32'h1);
    $display("t_pan done");
  endtask

  task automatic t_ack;
    logic [31:0] q;
    logic [3:0]  g;
    for (int t = 0; t < 3; t++)
    begin
      g = (t == 2) ? 4'd2 : 4'd0;
      wr(REG_ACK_CTRL, 32'(4 + t));
      wr(REG_ACK_DATA, 32'h11);
      wr(REG_ACK_DATA, 32'h22);
      rd(REG_ACK_CTRL, q);
      check(q, 32'(8 + t));
      push16(16'h0040);
      exp.push_back({2'b00, g, t[1:0]});
      push_t();
      if (t == 2)
        push16(16'h2211);
      req(KIND_ACK, (t == 2) ? 11 : 9, 2);
    end
    wr(REG_ACK_CTRL, 32'h3);
    rd(REG_STATUS, q);
    check(32'(q[2]), 32'h1);
    $display("t_ack done");
  endtask

  task automatic t_frag;
    wr(REG_CTRL, 32'h0);
    req_hdr <= '{1'b1, 1'b0, 2'b10, 2'b11, 16'hcafe, 16'h0, 64'h1234, 64'h0102030405060708};
    exp = '{8'h39, 8'hfe, 8'hca, 8'h34, 8'h12, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
    req(KIND_FRAG, 13, 1);
    req_hdr <= '{1'b0, 1'b0, 2'b01, 2'b00, 16'h0, 16'h0, 64'h99, 64'h0};
    exp = '{8'h04, 8'h99};
    req(KIND_FRAG, 2, 1);
    req(KIND_DATA, 0, 0);
    check(32'(req_ready), 32'h1);
    $display("t_frag done");
  endtask

  task automatic t_rx;
    logic [31:0] q;
    peer.send(1'b0, 16'h01ad);
    peer.send(1'b1, 16'h00c9);
    rd(REG_RX, q);
    check({10'h0, q[21:0]}, 32'h000901ad);
    $display("t_rx done");
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    resetn        = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0;
    req_valid     = 1'b0;
    req_kind      = KIND_DATA;
    req_hdr       = '0;
    slot_start_us = 48'h0a0b0c0d0e0f;
    slow          = 1'b0;
    n_mismatch    = 0;
    tests_run     = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_relay();
    t_pan();
    t_ack();
    t_frag();
    t_rx();
    finish_test();
  end
endmodule
